//--- pkg/mft_pkg.sv
// Constants and types shared by the multifunction timer mode control block
package mft_pkg;
	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam int unsigned MFT_AW = 8;
	localparam logic [7:0] MFT_OFF_CNT1 = 8'h00;
	localparam logic [7:0] MFT_OFF_CRA = 8'h04;
	localparam logic [7:0] MFT_OFF_CRB = 8'h08;
	localparam logic [7:0] MFT_OFF_CNT2 = 8'h0C;
	localparam logic [7:0] MFT_OFF_PND = 8'h10;
	localparam logic [7:0] MFT_OFF_PRSC = 8'h14;
	localparam logic [7:0] MFT_OFF_MCTRL = 8'h18;

	// ****************************************************************
	// Mode control field positions
	// ****************************************************************
	localparam int unsigned MFT_B_MODE = 0;
	localparam int unsigned MFT_B_AEDG = 2;
	localparam int unsigned MFT_B_BEDG = 3;
	localparam int unsigned MFT_B_AEN = 4;
	localparam int unsigned MFT_B_BEN = 5;
	localparam int unsigned MFT_B_AOUT = 6;
	localparam int unsigned MFT_B_EN = 7;
	localparam int unsigned MFT_B_PTEN = 8;
	localparam int unsigned MFT_B_PTSE = 9;
	localparam int unsigned MFT_B_PTET = 10;

	// Pending flag positions
	localparam int unsigned MFT_P_A = 0;
	localparam int unsigned MFT_P_B = 1;
	localparam int unsigned MFT_P_C = 2;
	localparam int unsigned MFT_P_D = 3;

	// ****************************************************************
	// Values and reset values
	// ****************************************************************
	localparam logic [15:0] MFT_CNT_PRESET = 16'hFFFF;
	localparam logic [15:0] MFT_CNT_RST = 16'h0000;
	localparam logic [7:0] MFT_PRSC_RST = 8'h00;
	localparam logic [3:0] MFT_PND_RST = 4'h0;
	localparam logic [31:0] MFT_RD_ZERO = 32'h00000000;

	typedef enum logic [1:0] {
		MFT_MODE_PWM,
		MFT_MODE_DUALCAP,
		MFT_MODE_DUALTMR,
		MFT_MODE_TMRCAP
	} mft_mode_e;
endpackage

//--- src/mft_mode_ctrl.sv
// Multifunction timer mode control with APB register slave
//
// Overview of operation
// - Selector: 0 PWM, 1 dualcap, 2 dual, 3 timcap
// - Edge polarity bit: 0 falling, 1 rising
// - Dualcap, B enabled: B edge presets counter1
// - Timcap, B enabled: B edge presets counter2
// - B enable inert outside both capture modes
// - Output data bit follows PWM pin level
// - Software write beats hardware toggle of output
// - Output bit inert when pin input/disabled
// - Enable bit; disabled stops counter clocks
// - Disabled: counter, reload, pending writes ignored
// - Disabled: prescaler and pending flags held reset
// - Disabled: first pin becomes input
// - Pulse-train enable in mode 0 selects train
// - Pulse-train enable inert in other modes
// - Software trigger mode: train starts on bit set
// - Hardware trigger mode: train starts on B edge
// - Counter2 underflow clears the event trigger bit
// - Hardware trigger mode ignores writes to trigger
// - Trigger bit reads 1 while train runs
`timescale 1ns/100ps
`default_nettype none
module mft_mode_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic first_timer_pin_in,
	input wire logic second_timer_pin_in,
	output logic first_timer_pin_out,
	output logic first_timer_pin_oe
);
	// ****************************************************************
	// State
	// ****************************************************************
	mft_pkg::mft_mode_e mode_q, mode_d;
	logic aedg_q, aedg_d, bedg_q, bedg_d, aen_q, aen_d, ben_q, ben_d;
	logic aout_q, aout_d, en_q, en_d, pten_q, pten_d;
	logic ptse_q, ptse_d, ptet_q, ptet_d;
	logic [15:0] cnt1_q, cnt1_d, cnt2_q, cnt2_d, cra_q, cra_d, crb_q, crb_d;
	logic [7:0] prsc_q, prsc_d;
	logic [3:0] pnd_q, pnd_d;
	logic [31:0] rdata_q, rdata_d;
	logic ready_q, ready_d, err_q, err_d, out_q, out_d, oe_q, oe_d;

	logic tick, a_evt, b_evt, run, uf1, uf2, pt_mode, hit;
	logic wr, wr_cnt1, wr_cnt2, wr_cra, wr_crb, wr_pnd, wr_prsc, wr_mctrl;
	logic cap_mode;
	logic [31:0] mctrl_rd;

	// ****************************************************************
	// Pin edges and prescaler
	// ****************************************************************
	mft_pin_edge u_edge_a (
		.pclk(pclk),
		.presetn(presetn),
		.pin(first_timer_pin_in),
		.rise_sel(aedg_q),
		.evt(a_evt)
	);

	mft_pin_edge u_edge_b (
		.pclk(pclk),
		.presetn(presetn),
		.pin(second_timer_pin_in),
		.rise_sel(bedg_q),
		.evt(b_evt)
	);

	// Prescaler only runs while enabled
	mft_prescaler u_prsc (
		.pclk(pclk),
		.presetn(presetn),
		.run(en_q),
		.div(prsc_q),
		.tick(tick)
	);

	// ****************************************************************
	// Decode
	// ****************************************************************
	assign wr = psel & penable & pwrite & ready_q;
	assign wr_cnt1 = wr & (paddr == mft_pkg::MFT_OFF_CNT1);
	assign wr_cra = wr & (paddr == mft_pkg::MFT_OFF_CRA);
	assign wr_crb = wr & (paddr == mft_pkg::MFT_OFF_CRB);
	assign wr_cnt2 = wr & (paddr == mft_pkg::MFT_OFF_CNT2);
	assign wr_pnd = wr & (paddr == mft_pkg::MFT_OFF_PND);
	assign wr_prsc = wr & (paddr == mft_pkg::MFT_OFF_PRSC);
	assign wr_mctrl = wr & (paddr == mft_pkg::MFT_OFF_MCTRL);
	assign hit = (paddr == mft_pkg::MFT_OFF_CNT1) | (paddr == mft_pkg::MFT_OFF_CRA) |
		(paddr == mft_pkg::MFT_OFF_CRB) | (paddr == mft_pkg::MFT_OFF_CNT2) |
		(paddr == mft_pkg::MFT_OFF_PND) | (paddr == mft_pkg::MFT_OFF_PRSC) |
		(paddr == mft_pkg::MFT_OFF_MCTRL);

	// Train mode exists only with selector 0
	assign pt_mode = (mode_q == mft_pkg::MFT_MODE_PWM) & pten_q;
	// In train mode counters only run while a train is active
	assign run = en_q & tick & (~pt_mode | ptet_q);
	assign uf1 = run & (cnt1_q == 16'h0000);
	assign uf2 = run & (cnt2_q == 16'h0000);
	assign cap_mode = (mode_q == mft_pkg::MFT_MODE_DUALCAP) |
		(mode_q == mft_pkg::MFT_MODE_TMRCAP);
	assign mctrl_rd = {21'h000000, ptet_q, ptse_q, pten_q, en_q, aout_q, ben_q, aen_q,
		bedg_q, aedg_q, mode_q};

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		mode_d = mode_q;
		aedg_d = aedg_q;
		bedg_d = bedg_q;
		aen_d = aen_q;
		ben_d = ben_q;
		aout_d = aout_q;
		en_d = en_q;
		pten_d = pten_q;
		ptse_d = ptse_q;
		ptet_d = ptet_q;
		cnt1_d = cnt1_q;
		cnt2_d = cnt2_q;
		cra_d = cra_q;
		crb_d = crb_q;
		prsc_d = prsc_q;
		pnd_d = pnd_q;

		// Counting
		if (run) begin
			cnt1_d = uf1 ? cra_q : cnt1_q - 16'h0001;
			cnt2_d = uf2 ? crb_q : cnt2_q - 16'h0001;
		end
		if (uf1 && mode_q == mft_pkg::MFT_MODE_PWM) begin
			aout_d = ~aout_q;
		end
		// Pulse train: hardware start on B edge, end on underflow
		if (en_q && pt_mode && !ptse_q && b_evt) begin
			ptet_d = 1'b1;
		end
		if (pt_mode && uf2) begin
			ptet_d = 1'b0;
		end

		// Software writes to counters, reloads and pending allowed only while enabled; prescaler and mode control writes always
		if (en_q) begin
			if (wr_cnt1) begin
				cnt1_d = pwdata[15:0];
			end
			if (wr_cnt2) begin
				cnt2_d = pwdata[15:0];
			end
			if (wr_cra) begin
				cra_d = pwdata[15:0];
			end
			if (wr_crb) begin
				crb_d = pwdata[15:0];
			end
			if (wr_pnd) begin
				pnd_d = pnd_q & ~pwdata[3:0];
			end
		end
		if (wr_prsc) begin
			prsc_d = pwdata[7:0];
		end
		if (wr_mctrl) begin
			mode_d = mft_pkg::mft_mode_e'(pwdata[mft_pkg::MFT_B_MODE +: 2]);
			aedg_d = pwdata[mft_pkg::MFT_B_AEDG];
			bedg_d = pwdata[mft_pkg::MFT_B_BEDG];
			aen_d = pwdata[mft_pkg::MFT_B_AEN];
			ben_d = pwdata[mft_pkg::MFT_B_BEN];
			aout_d = pwdata[mft_pkg::MFT_B_AOUT];
			en_d = pwdata[mft_pkg::MFT_B_EN];
			pten_d = pwdata[mft_pkg::MFT_B_PTEN];
			ptse_d = pwdata[mft_pkg::MFT_B_PTSE];
			if (!(pt_mode && !ptse_q)) begin
				ptet_d = pwdata[mft_pkg::MFT_B_PTET];
			end
		end

		// Captures and B-pin presets override software writes
		if (en_q && aen_q && cap_mode && a_evt) begin
			cra_d = cnt1_q;
		end
		if (en_q && ben_q && b_evt) begin
			case (mode_q)
				mft_pkg::MFT_MODE_DUALCAP: begin
					crb_d = cnt1_q;
					cnt1_d = mft_pkg::MFT_CNT_PRESET;
				end
				mft_pkg::MFT_MODE_TMRCAP: begin
					crb_d = cnt2_q;
					cnt2_d = mft_pkg::MFT_CNT_PRESET;
				end
				default: begin
				end
			endcase
		end

		// Pending flags: set wins over clear, all held reset while disabled
		if (uf1) begin
			pnd_d[mft_pkg::MFT_P_A] = 1'b1;
		end
		if (en_q && aen_q && cap_mode && a_evt) begin
			pnd_d[mft_pkg::MFT_P_B] = 1'b1;
		end
		if (en_q && ben_q && cap_mode && b_evt) begin
			pnd_d[mft_pkg::MFT_P_C] = 1'b1;
		end
		if (uf2) begin
			pnd_d[mft_pkg::MFT_P_D] = 1'b1;
		end
		if (!en_q) begin
			pnd_d = mft_pkg::MFT_PND_RST;
		end
	end

	// Pin driven only when enabled in PWM mode; data bit inert otherwise
	always_comb begin
		oe_d = en_d & (mode_d == mft_pkg::MFT_MODE_PWM);
		out_d = oe_d & aout_d;
	end

	// APB slave: one wait state, error on unmapped address
	always_comb begin
		ready_d = psel & penable & ~ready_q;
		err_d = ready_d & ~hit;
		rdata_d = rdata_q;
		if (ready_d && !pwrite) begin
			case (paddr)
				mft_pkg::MFT_OFF_CNT1: rdata_d = {16'h0000, cnt1_q};
				mft_pkg::MFT_OFF_CRA: rdata_d = {16'h0000, cra_q};
				mft_pkg::MFT_OFF_CRB: rdata_d = {16'h0000, crb_q};
				mft_pkg::MFT_OFF_CNT2: rdata_d = {16'h0000, cnt2_q};
				mft_pkg::MFT_OFF_PND: rdata_d = {28'h0000000, pnd_q};
				mft_pkg::MFT_OFF_PRSC: rdata_d = {24'h000000, prsc_q};
				mft_pkg::MFT_OFF_MCTRL: rdata_d = mctrl_rd;
				default: rdata_d = mft_pkg::MFT_RD_ZERO;
			endcase
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= mft_pkg::MFT_MODE_PWM;
			aedg_q <= 1'b0;
			bedg_q <= 1'b0;
			aen_q <= 1'b0;
			ben_q <= 1'b0;
			aout_q <= 1'b0;
			en_q <= 1'b0;
			pten_q <= 1'b0;
			ptse_q <= 1'b0;
			ptet_q <= 1'b0;
			cnt1_q <= mft_pkg::MFT_CNT_RST;
			cnt2_q <= mft_pkg::MFT_CNT_RST;
			cra_q <= mft_pkg::MFT_CNT_RST;
			crb_q <= mft_pkg::MFT_CNT_RST;
			prsc_q <= mft_pkg::MFT_PRSC_RST;
			pnd_q <= mft_pkg::MFT_PND_RST;
			rdata_q <= mft_pkg::MFT_RD_ZERO;
			ready_q <= 1'b0;
			err_q <= 1'b0;
			out_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			aedg_q <= aedg_d;
			bedg_q <= bedg_d;
			aen_q <= aen_d;
			ben_q <= ben_d;
			aout_q <= aout_d;
			en_q <= en_d;
			pten_q <= pten_d;
			ptse_q <= ptse_d;
			ptet_q <= ptet_d;
			cnt1_q <= cnt1_d;
			cnt2_q <= cnt2_d;
			cra_q <= cra_d;
			crb_q <= crb_d;
			prsc_q <= prsc_d;
			pnd_q <= pnd_d;
			rdata_q <= rdata_d;
			ready_q <= ready_d;
			err_q <= err_d;
			out_q <= out_d;
			oe_q <= oe_d;
		end
	end

	assign prdata = rdata_q;
	assign pready = ready_q;
	assign pslverr = err_q;
	assign first_timer_pin_out = out_q;
	assign first_timer_pin_oe = oe_q;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_sw_start;
		en_q && pt_mode && ptse_q && !ptet_q && wr_mctrl && pwdata[mft_pkg::MFT_B_PTET]
			&& pwdata[mft_pkg::MFT_B_PTEN] && pwdata[mft_pkg::MFT_B_PTSE]
			&& pwdata[1:0] == 2'h0;
	endsequence

	property p_preset_cnt1;
		en_q && ben_q && mode_q == mft_pkg::MFT_MODE_DUALCAP && b_evt
			|=> cnt1_q == 16'hFFFF;
	endproperty
	a_preset_cnt1: assert property (p_preset_cnt1) else $error("counter1 not preset");

	property p_preset_cnt2;
		en_q && ben_q && mode_q == mft_pkg::MFT_MODE_TMRCAP && b_evt
			|=> cnt2_q == 16'hFFFF;
	endproperty
	a_preset_cnt2: assert property (p_preset_cnt2) else $error("counter2 not preset");

	property p_ben_inert;
		b_evt && !cap_mode && !tick && !wr && !(pt_mode && !ptse_q)
			|=> $stable(cnt1_q) && $stable(cnt2_q);
	endproperty
	a_ben_inert: assert property (p_ben_inert) else $error("B edge moved a counter");

	property p_sw_wins;
		wr_mctrl |=> aout_q == $past(pwdata[mft_pkg::MFT_B_AOUT]);
	endproperty
	a_sw_wins: assert property (p_sw_wins) else $error("output bit write lost");

	property p_stopped;
		!en_q |=> $stable(cnt1_q) && $stable(cnt2_q) && $stable(cra_q);
	endproperty
	a_stopped: assert property (p_stopped) else $error("counter moved while off");

	property p_pnd_reset;
		!en_q |=> pnd_q == 4'h0;
	endproperty
	a_pnd_reset: assert property (p_pnd_reset) else $error("pending kept while off");

	property p_pin_input;
		!en_q && !wr_mctrl |=> !first_timer_pin_oe && !first_timer_pin_out;
	endproperty
	a_pin_input: assert property (p_pin_input) else $error("pin driven while off");

	property p_sw_start;
		s_sw_start |=> ptet_q;
	endproperty
	a_sw_start: assert property (p_sw_start) else $error("train not started");

	property p_hw_start;
		en_q && pt_mode && !ptse_q && b_evt && !uf2 |=> ptet_q;
	endproperty
	a_hw_start: assert property (p_hw_start) else $error("B edge did not start");

	property p_end;
		pt_mode && uf2 && !wr_mctrl |=> !ptet_q;
	endproperty
	a_end: assert property (p_end) else $error("trigger not cleared");

	property p_ignore;
		pt_mode && !ptse_q && wr_mctrl && !b_evt && !uf2 |=> ptet_q == $past(ptet_q);
	endproperty
	a_ignore: assert property (p_ignore) else $error("trigger write taken");
endmodule
`default_nettype wire

//--- src/mft_pin_edge.sv
// Pin synchroniser with polarity-qualified edge detection
`timescale 1ns/100ps
`default_nettype none
module mft_pin_edge (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pin,
	input wire logic rise_sel,
	output logic evt
);
	logic s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;

	always_comb begin
		s1_d = pin;
		s2_d = s1_q;
		s3_d = s2_q;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
		end
	end

	// Edge is taken only after two stages, then qualified by polarity
	assign evt = rise_sel ? (s2_q & ~s3_q) : (~s2_q & s3_q);
endmodule
`default_nettype wire

//--- src/mft_prescaler.sv
// Eight-bit clock prescaler, held in reset while not running
`timescale 1ns/100ps
`default_nettype none
module mft_prescaler (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic [7:0] div,
	output logic tick
);
	logic [7:0] cnt_q, cnt_d;

	always_comb begin
		if (!run || cnt_q == div) begin
			cnt_d = mft_pkg::MFT_PRSC_RST;
		end else begin
			cnt_d = cnt_q + 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= mft_pkg::MFT_PRSC_RST;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign tick = run & (cnt_q == div);
endmodule
`default_nettype wire

//--- tb/mft_pin_model.sv
// External drivers on the two timer pins
`timescale 1ns/100ps
`default_nettype none
module mft_pin_model (
	input wire logic pclk,
	input wire logic a_oe,
	input wire logic a_out,
	input wire logic b_set,
	output logic a_in,
	output logic b_in
);
	// ********
	// Pin levels
	// ********
	logic a_ext = 1'h0;
	logic b_q = 1'h0;
	// Far driver keeps pin A busy while the block has released it
	always @(posedge pclk) begin
		a_ext <= ~a_ext;
		b_q <= b_set;
	end
	// Wire level of the two-way pin A
	assign a_in = a_oe ? a_out : a_ext;
	assign b_in = b_q;
endmodule
`default_nettype wire

//--- tb/test_multifunction_timer_mode_control.sv
// Self-checking bench for the timer mode control block
`timescale 1ns/100ps
`default_nettype none
module test_multifunction_timer_mode_control;
	// ********
	// Signals
	// ********
	localparam logic [7:0] MC = mft_pkg::MFT_OFF_MCTRL;
	localparam logic [7:0] C1 = mft_pkg::MFT_OFF_CNT1;
	localparam logic [7:0] C2 = mft_pkg::MFT_OFF_CNT2;
	localparam logic [7:0] RA = mft_pkg::MFT_OFF_CRA;
	localparam logic [7:0] RB = mft_pkg::MFT_OFF_CRB;
	localparam logic [7:0] PN = mft_pkg::MFT_OFF_PND;
	localparam logic [7:0] PS = mft_pkg::MFT_OFF_PRSC;
	localparam logic [31:0] EN = 32'h00000080;
	localparam logic [31:0] PT = 32'h00000100;
	localparam logic [31:0] SE = 32'h00000200;
	localparam logic [31:0] ET = 32'h00000400;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic a_in;
	logic b_in;
	logic a_out;
	logic a_oe;
	logic b_set = 1'h0;
	int mismatches = 0;
	int n_compared = 0;
	logic [31:0] d;
	logic e;

	always #5 pclk = ~pclk;

	mft_mode_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .first_timer_pin_in(a_in), .second_timer_pin_in(b_in),
		.first_timer_pin_out(a_out), .first_timer_pin_oe(a_oe));
	mft_pin_model mdl (.pclk(pclk), .a_oe(a_oe), .a_out(a_out), .b_set(b_set),
		.a_in(a_in), .b_in(b_in));

	// ********
	// Shared tasks
	// ********
	task give_verdict;
		if (mismatches == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task timeout;
		mismatches++;
		$display("CHECK FAILED wait bound exp done got timeout");
		give_verdict();
	endtask

	task check(input string nm, input logic [31:0] s, input logic [31:0] x);
		n_compared++;
		if (s !== x) begin
			mismatches++;
			$display("CHECK FAILED %s exp %h got %h", nm, x, s);
		end
	endtask

	task cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rv, output logic er);
		int n;
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
			if (n > 20) timeout();
		end while (pready !== 1'h1);
		rv = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] v);
		apb(1'h1, a, v, d, e);
	endtask

	task rd(input logic [7:0] a, output logic [31:0] v);
		apb(1'h0, a, 32'h00000000, v, e);
	endtask

	task drive_b(input logic v);
		@(posedge pclk);
		b_set <= v;
		cyc(8);
	endtask

	// Polls the trigger bit until the train ends, then counter2 must rest at its reload
	task wait_clear(input logic [31:0] rl);
		int n;
		n = 0;
		do begin
			rd(MC, d);
			n++;
			if (n > 60) timeout();
		end while (d[10] !== 1'h0);
		cyc(4);
		rd(C2, d);
		check("train stopped at reload", d, rl);
	endtask

	// ********
	// Scenarios
	// ********
	task t_reset;
		for (int a = 0; a <= 24; a += 4) begin
			rd(8'(a), d);
			check("reset value", d, 32'h00000000);
		end
		check("pin oe at reset", a_oe, 1'h0);
	endtask

	task t_locked;
		for (int a = 0; a <= 16; a += 4) begin
			wr(8'(a), 32'h00001234);
			rd(8'(a), d);
			check("locked reg", d, 32'h00000000);
		end
		wr(PS, 32'h00000001);
		rd(PS, d);
		check("divider", d, 32'h00000001);
		wr(MC, 32'h00000040);
		cyc(2);
		check("pin oe off", a_oe, 1'h0);
		check("pin out idle", a_out, 1'h0);
	endtask

	task t_preset(input logic [1:0] m, input logic [7:0] off, input logic [7:0] hi);
		wr(MC, EN | 32'h00000020 | {30'h0, m});
		rd(MC, d);
		check("mode field", d[1:0], m);
		wr(off, 32'h00001234);
		drive_b(1'h1);
		rd(off, d);
		check("no preset on rise", d[15:8], 8'h12);
		drive_b(1'h0);
		rd(off, d);
		check("preset on fall", d[15:8], hi);
		wr(MC, 32'h00000000);
	endtask

	task t_pwm;
		logic v;
		int n;
		wr(MC, EN);
		wr(RA, 32'h000000FF);
		wr(C1, 32'h000000FF);
		cyc(2);
		check("pin driven", a_oe, 1'h1);
		v = a_out;
		n = 0;
		while (a_out === v && n < 2000) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 2000) timeout();
		rd(MC, d);
		check("out data bit", d[6], a_out);
		v = a_out;
		wr(MC, v ? EN : EN | 32'h00000040);
		cyc(2);
		check("sw write wins", a_out, {31'h00000000, !v});
		wr(MC, 32'h00000040);
		cyc(2);
		check("released pin", a_oe, 1'h0);
		check("inert out bit", a_out, 1'h0);
	endtask

	task t_train_sw;
		wr(MC, EN | PT | SE);
		wr(C2, 32'h00000008);
		wr(RB, 32'h00000008);
		cyc(10);
		rd(C2, d);
		check("train waits", d, 32'h00000008);
		wr(MC, EN | PT | SE | ET);
		rd(MC, d);
		check("sw trigger set", d[10], 1'h1);
		wait_clear(32'h00000008);
		rd(PN, d);
		check("cnt2 underflow flag", d[3], 1'h1);
		wr(MC, 32'h00000000);
		rd(PN, d);
		check("flags cleared", d, 32'h00000000);
	endtask

	task t_train_hw;
		wr(MC, EN | PT | 32'h00000008);
		wr(C2, 32'h00000020);
		wr(RB, 32'h00000020);
		wr(MC, EN | PT | ET | 32'h00000008);
		rd(MC, d);
		check("trigger write ignored", d[10], 1'h0);
		drive_b(1'h1);
		rd(MC, d);
		check("hw train running", d[10], 1'h1);
		wait_clear(32'h00000020);
		drive_b(1'h0);
		wr(MC, 32'h00000000);
	endtask

	task t_unmapped;
		apb(1'h1, 8'h40, 32'hFFFFFFFF, d, e);
		check("unmapped write err", e, 1'h1);
		apb(1'h0, 8'h40, 32'h00000000, d, e);
		check("unmapped read err", e, 1'h1);
		check("unmapped read data", d, 32'h00000000);
	endtask

	// ********
	// Main sequence
	// ********
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		t_reset();
		t_locked();
		t_preset(2'h1, C1, 8'hFF);
		t_preset(2'h3, C2, 8'hFF);
		t_preset(2'h2, C1, 8'h12);
		t_pwm();
		t_train_sw();
		t_train_hw();
		t_unmapped();
		give_verdict();
	end
endmodule
`default_nettype wire
